// ### verilog/sbc_pkg.sv
// constants shared by the serial baud clock control block
// assumes a single 200 MHz core clock and a 32-bit avalon slave port
`default_nettype none
package sbc_pkg;
  // byte offsets on the register bus
  localparam logic [3:0] ADDR_DIV_HI = 4'h0;
  localparam logic [3:0] ADDR_DIV_LO = 4'h4;
  localparam logic [3:0] ADDR_CFG = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  // clock_config_register fields
  localparam int CFG_W = 6;
  localparam int CFG_CLK_DIVIDE_SELECT = 0;
  localparam int CFG_TX_PIN_SEL_A = 1;
  localparam int CFG_TX_PIN_SEL_B = 2;
  localparam int CFG_RX_EXT_CLK_EN = 3;
  localparam int CFG_GEN_SRC_RX_PIN = 4;
  localparam int CFG_SYNC_MODE_EN = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
  localparam logic [7:0] DIV_BYTE_RESET = 8'h00;
  // status fields
  localparam int ST_ENABLED = 0;
  localparam int ST_GEN_RUNNING = 1;
  localparam int ST_GEN_OUT = 2;
  localparam int ST_SER_EXPANSION = 3;
  // tx pin function codes {sel_a, sel_b}
  localparam logic [1:0] PIN_TX_CLK_IN = 2'h0;
  localparam logic [1:0] PIN_GEN_OUT = 2'h1;
  localparam logic [1:0] PIN_SCLK_OUT = 2'h2;
  localparam logic [1:0] PIN_SER_EXPANSION = 2'h3;
  // divider limits and bit clock prescale
  localparam int DIV_W = 16;
  localparam logic [15:0] MIN_DIVISOR = 16'h0002;
  localparam int BIT_PRESCALE = 16;
  localparam int PRESCALE_W = 4;
  // timing: core clock period, internal system clock is core clock / 2
  localparam int CORE_PERIOD_NS = 5;
  localparam int CORE_CLK_HZ = 1000000000 / CORE_PERIOD_NS;
  localparam int INT_CLK_HZ = CORE_CLK_HZ / 2;
  // top rates reached at the minimum divisor
  localparam int MAX_BAUD_UNDIV = INT_CLK_HZ / 2;
  localparam int MAX_BAUD_DIV16 = INT_CLK_HZ / (2 * BIT_PRESCALE);
endpackage
`default_nettype wire

// ### verilog/sbc_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk
`default_nettype none
module sbc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### verilog/sbc_divider.sv
// divide-by-n baud generator counting half periods of its input clock
// assumes halfEdge pulses once per edge (both) of the selected input clock
`default_nettype none
module sbc_divider #(
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic halfEdge,
  input wire logic [DW-1:0] divisor,
  output logic serial_clock_output,
  output logic running
);
  logic [DW-1:0] cnt_q;
  logic valid;

  assign valid = divisor >= DW'(sbc_pkg::MIN_DIVISOR);

  // toggling every n half periods gives exact 50% duty for odd n too
  always_ff @(posedge clk) begin
    if (rst || !enable || !valid) begin
      cnt_q <= divisor;
      serial_clock_output <= 1'b0;
      running <= 1'b0;
    end else begin
      running <= 1'b1;
      if (halfEdge) begin
        if (cnt_q <= DW'(1)) begin
          cnt_q <= divisor;
          serial_clock_output <= ~serial_clock_output;
        end else begin
          cnt_q <= cnt_q - DW'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/sbc_top.sv
// serial baud clock control: divisor registers, baud generator,
// bit clock prescale and external clock pin handling
// assumes avalon-mm master on core_clk; pins are asynchronous
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`default_nettype none

// What this block does
// - bit clock divided by 16 when divide select clear, else undivided
// - internal clock only: top rates are input clock over 2 and over 32
// - external clocks: same undivided top, prescaled rate bounded by pin
// - two select bits make tx pin clock input, generator out or sclk
// - rx bit clock takes the rx external clock only when its enable bit is set
// - generator is a 16-bit programmable divide-by-n counter
// - valid divisors run from 2 to 65535
// - counter reloaded from divisor while stopped; first count after start keeps the old low byte
// - generator output is input clock divided by divisor
// - divisor of zero or one stops the divider, no output
// - generator output has exact 50% duty for any divisor
// - generator can run from the internal system clock
// - writing the high byte disables and resets generator, tx, rx
// - writing the low byte re-enables tx, rx and starts the generator
// - synchronous receive data and clock resynchronised to core clock
// - generator input selects internal clock or rx external clock
// - select 11 without synchronous mode gives serial expansion mode
// - select 00 with synchronous mode disables the serial clock output
module sbc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxExtClkPin,
  input wire logic rxDataPin,
  input wire logic txPinIn,
  output logic txPinOut,
  output logic txPinOe,
  input wire logic serialClockFromTx,
  output logic txBitClk,
  output logic txBitTick,
  output logic rxBitClk,
  output logic rxBitTick,
  output logic rxDataSync,
  output logic serialIfReset,
  output logic serialExpansionMode
);
  logic [7:0] divHi_q;
  logic [7:0] divLo_q;
  logic [sbc_pkg::CFG_W-1:0] cfg_q;
  logic enable_q;
  logic ack;
  logic wrEn;
  logic [2:0] pinSync;
  logic rxClkSync;
  logic txClkSync;
  logic rxClkPrev_q;
  logic internal_system_clock_q;
  logic genHalfEdge;
  logic genOut;
  logic genRunning;
  logic [1:0] pinFunc;
  logic clkDivSel;
  logic synchronous_mode_enable;
  logic [1:0] chanSrc;
  logic [1:0] chanBitClk_q;
  logic [1:0] chanTick_q;

  assign ack = (avs_read || avs_write) && !avs_waitrequest;
  assign wrEn = avs_write && ack && avs_byteenable[0];
  assign pinFunc = {cfg_q[sbc_pkg::CFG_TX_PIN_SEL_A],
                    cfg_q[sbc_pkg::CFG_TX_PIN_SEL_B]};
  assign clkDivSel = cfg_q[sbc_pkg::CFG_CLK_DIVIDE_SELECT];
  assign synchronous_mode_enable = cfg_q[sbc_pkg::CFG_SYNC_MODE_EN];

  // one wait cycle per access, then the answer edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (ack) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        sbc_pkg::ADDR_DIV_HI: avs_readdata <= {24'h000000, divHi_q};
        sbc_pkg::ADDR_DIV_LO: avs_readdata <= {24'h000000, divLo_q};
        sbc_pkg::ADDR_CFG: avs_readdata <= {26'h0000000, cfg_q};
        sbc_pkg::ADDR_STATUS: begin
          avs_readdata <= 32'h00000000;
          avs_readdata[sbc_pkg::ST_ENABLED] <= enable_q;
          avs_readdata[sbc_pkg::ST_GEN_RUNNING] <= genRunning;
          avs_readdata[sbc_pkg::ST_GEN_OUT] <= genOut;
          avs_readdata[sbc_pkg::ST_SER_EXPANSION] <= serialExpansionMode;
        end
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      divHi_q <= sbc_pkg::DIV_BYTE_RESET;
      divLo_q <= sbc_pkg::DIV_BYTE_RESET;
      cfg_q <= sbc_pkg::CFG_RESET;
    end else if (wrEn) begin
      case (avs_address)
        sbc_pkg::ADDR_DIV_HI: divHi_q <= avs_writedata[7:0];
        sbc_pkg::ADDR_DIV_LO: divLo_q <= avs_writedata[7:0];
        sbc_pkg::ADDR_CFG: cfg_q <= avs_writedata[sbc_pkg::CFG_W-1:0];
        default: ;
      endcase
    end
  end

  // high byte holds everything in reset until the low byte lands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      enable_q <= 1'b0;
    end else if (wrEn && avs_address == sbc_pkg::ADDR_DIV_HI) begin
      enable_q <= 1'b0;
    end else if (wrEn && avs_address == sbc_pkg::ADDR_DIV_LO) begin
      enable_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      serialIfReset <= 1'b1;
    end else begin
      serialIfReset <= !enable_q ||
        (wrEn && avs_address == sbc_pkg::ADDR_DIV_LO);
    end
  end

  sbc_sync #(.W(3)) u_pinSync (
    .clk(core_clk),
    .rst(rst),
    .din({rxExtClkPin, txPinIn, rxDataPin}),
    .dout(pinSync)
  );
  assign rxClkSync = pinSync[2];
  assign txClkSync = pinSync[1];
  assign rxDataSync = pinSync[0];

  // internal system clock is core clock / 2, so each core edge is a half
  always_ff @(posedge core_clk) begin
    if (rst) begin
      internal_system_clock_q <= 1'b0;
      rxClkPrev_q <= 1'b0;
    end else begin
      internal_system_clock_q <= ~internal_system_clock_q;
      rxClkPrev_q <= rxClkSync;
    end
  end

  // external source counts both edges of the resynchronised pin
  assign genHalfEdge = cfg_q[sbc_pkg::CFG_GEN_SRC_RX_PIN] ?
    (rxClkSync != rxClkPrev_q) : 1'b1;

  sbc_divider #(.DW(sbc_pkg::DIV_W)) u_divider (
    .clk(core_clk),
    .rst(rst),
    .enable(enable_q),
    .halfEdge(genHalfEdge),
    .divisor({divHi_q, divLo_q}),
    .serial_clock_output(genOut),
    .running(genRunning)
  );

  // source before prescale: index 0 transmit, index 1 receive
  assign chanSrc[0] = (pinFunc == sbc_pkg::PIN_TX_CLK_IN) ?
    txClkSync : genOut;
  assign chanSrc[1] = cfg_q[sbc_pkg::CFG_RX_EXT_CLK_EN] ?
    rxClkSync : genOut;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic srcPrev_q;
      logic [sbc_pkg::PRESCALE_W-1:0] pre_q;
      logic bitNext;
      assign bitNext = clkDivSel ? chanSrc[ch] :
        pre_q[sbc_pkg::PRESCALE_W-1];
      always_ff @(posedge core_clk) begin
        if (rst || !enable_q) begin
          srcPrev_q <= 1'b0;
          pre_q <= '0;
          chanBitClk_q[ch] <= 1'b0;
          chanTick_q[ch] <= 1'b0;
        end else begin
          srcPrev_q <= chanSrc[ch];
          // top of the prescaler toggles once per 8 source periods
          if (chanSrc[ch] && !srcPrev_q) begin
            pre_q <= pre_q + sbc_pkg::PRESCALE_W'(1);
          end
          chanBitClk_q[ch] <= bitNext;
          chanTick_q[ch] <= bitNext && !chanBitClk_q[ch];
        end
      end
    end
  endgenerate

  assign txBitClk = chanBitClk_q[0];
  assign rxBitClk = chanBitClk_q[1];
  assign txBitTick = chanTick_q[0];
  assign rxBitTick = chanTick_q[1];

  // pin driver; limits the rates to those by construction
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txPinOut <= 1'b0;
      txPinOe <= 1'b0;
      serialExpansionMode <= 1'b0;
    end else begin
      serialExpansionMode <= !synchronous_mode_enable &&
        pinFunc == sbc_pkg::PIN_SER_EXPANSION;
      case (pinFunc)
        sbc_pkg::PIN_TX_CLK_IN: begin
          txPinOut <= 1'b0;
          txPinOe <= 1'b0;
        end
        sbc_pkg::PIN_GEN_OUT: begin
          txPinOut <= genOut;
          txPinOe <= enable_q;
        end
        sbc_pkg::PIN_SCLK_OUT, sbc_pkg::PIN_SER_EXPANSION: begin
          txPinOut <= serialClockFromTx;
          txPinOe <= enable_q;
        end
        default: begin
          txPinOut <= 1'b0;
          txPinOe <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/sbc_ext_src.sv
// stand-in for the external clock source and serial data line
// assumes run is driven off the core clock edge by the bench
`default_nettype none
module sbc_ext_src #(
  parameter real HALF = 20.0
) (
  input wire logic run,
  output logic rxExtClkPin,
  output logic txPinIn,
  output logic rxDataPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // odd phase keeps pin edges away from core clock edges
  initial begin
    rxExtClkPin = 1'b0;
    txPinIn = 1'b0;
    rxDataPin = 1'b1;
    #1.3;
    forever begin
      #(HALF);
      rxDataPin = ~rxDataPin;
      // clock stands still while idle, 50% duty while running
      if (run) begin
        rxExtClkPin = ~rxExtClkPin;
        txPinIn = rxExtClkPin;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/sbc_top_assertions.sv
// port checker for sbc_top
// assumes it is bound onto every sbc_top instance
`default_nettype none
module sbc_top_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic rxDataPin,
  input wire logic txPinOe,
  input wire logic txBitClk,
  input wire logic txBitTick,
  input wire logic rxBitClk,
  input wire logic rxBitTick,
  input wire logic rxDataSync,
  input wire logic serialIfReset,
  input wire logic serialExpansionMode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic wrAck;
  assign wrAck = avs_write && !avs_waitrequest && avs_byteenable[0];
  AST_TAKE: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bad ack");
  AST_HI: assert property (
    wrAck && avs_address == sbc_pkg::ADDR_DIV_HI |=> ##[0:2] serialIfReset)
    else $error("high byte write did not reset");
  AST_LO: assert property (
    wrAck && avs_address == sbc_pkg::ADDR_DIV_LO |=> ##[0:2] !serialIfReset)
    else $error("low byte write did not enable");
  // tick and bit clock are registered on the same edge, so they rise together
  AST_TXTICK: assert property ($rose(txBitClk) |-> txBitTick)
    else $error("tx tick missing");
  AST_RXTICK: assert property ($rose(rxBitClk) |-> rxBitTick)
    else $error("rx tick missing");
  AST_GAP: assert property (txBitTick |=> !txBitTick [*3])
    else $error("tx bit clock too fast");
  // in expansion mode the pin is driven whenever the interface is out of reset
  AST_SEXP: assert property (
    serialExpansionMode && !serialIfReset |-> txPinOe)
    else $error("expansion mode without pin drive");
  AST_RXSYNC: assert property (!$past(rst) && !$past(rst, 2)
    |-> rxDataSync == $past(rxDataPin, 2)) else $error("rx data sync");
endmodule
bind sbc_top sbc_top_chk u_chk (.core_clk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_byteenable, .avs_waitrequest, .rxDataPin, .txPinOe,
  .txBitClk, .txBitTick, .rxBitClk, .rxBitTick, .rxDataSync,
  .serialIfReset, .serialExpansionMode);
`default_nettype wire

// ### tb/tb_top.sv
// bench for sbc_top: avalon access tasks and bit clock checks
// assumes sbc_ext_src drives the clock and data pins
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PP = 8;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic run = 1'b0;
  logic serialClockFromTx = 1'b1;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, rxExtClkPin, rxDataPin, txPinIn, txPinOut;
  logic txPinOe, txBitClk, txBitTick, rxBitClk, rxBitTick, rxDataSync;
  logic serialIfReset, serialExpansionMode;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  logic [15:0] dv [3] = '{16'h0002, 16'h0003, 16'h0105};
  sbc_top DUT (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .rxExtClkPin, .rxDataPin, .txPinIn, .txPinOut, .txPinOe,
    .serialClockFromTx, .txBitClk, .txBitTick, .rxBitClk, .rxBitTick,
    .rxDataSync, .serialIfReset, .serialExpansionMode);
  sbc_ext_src #(.HALF(PP * 2.5)) ext (.run, .rxExtClkPin, .txPinIn,
    .rxDataPin);
  initial forever #2.5 core_clk = ~core_clk;
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic to();
    miscompares++;
    $display("mismatch at %0t: wait ran out", $time);
    test_done();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a,
    input logic [7:0] d, output logic [31:0] r);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i >= 50) to();
  endtask
  // full reinit order: high byte, control, then low byte to enable
  task automatic init(input logic [5:0] c, input logic [15:0] d);
    acc(1'b1, sbc_pkg::ADDR_DIV_HI, d[15:8], q);
    acc(1'b1, sbc_pkg::ADDR_CFG, {2'h0, c}, q);
    acc(1'b0, sbc_pkg::ADDR_CFG, 8'h0, q);
    chk(q, {26'h0, c});
    acc(1'b1, sbc_pkg::ADDR_DIV_LO, d[7:0], q);
    repeat (4) @(posedge core_clk);
    chk(serialIfReset, 1'b0);
  endtask
  // cycles between the second and third bit tick seen
  task automatic per(input logic rx, output int p);
    int k;
    p = 0;
    for (k = 0; k < 3 && p < 3000; p++) begin
      @(posedge core_clk);
      if ((rx ? rxBitTick : txBitTick) === 1'b1) begin
        k++;
        if (k < 3) p = -1;
      end
    end
    if (p >= 3000) to();
  endtask
  task automatic lo(output int p);
    for (p = 0; p < 999 && txBitClk !== 1'b0; p++) @(posedge core_clk);
    for (p = 0; p < 999 && txBitClk === 1'b0; p++) @(posedge core_clk);
    if (p >= 999) to();
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    chk(serialIfReset, 1'b1);
    chk(txPinOe, 1'b0);
    acc(1'b0, 4'h2, 8'h0, q);
    chk(q, 32'h0);
    foreach (dv[i]) begin
      init(6'h05, dv[i]);
      per(1'b0, n);
      chk(n, 2 * dv[i]);
      lo(n);
      chk(n, dv[i]);
      chk(txPinOe, 1'b1);
    end
    init(6'h04, 16'h0002);
    per(1'b0, n);
    chk(n, 2 * 2 * sbc_pkg::BIT_PRESCALE);
    for (int d = 0; d < 2; d++) begin
      init(6'h05, 16'(d));
      n = 0;
      repeat (300) begin
        @(posedge core_clk);
        n += (txBitTick !== 1'b0);
      end
      chk(n, 0);
      acc(1'b0, sbc_pkg::ADDR_STATUS, 8'h0, q);
      chk(q[sbc_pkg::ST_GEN_RUNNING], 1'b0);
    end
    run <= 1'b1;
    init(6'h11, 16'h0002);
    per(1'b1, n);
    chk(n, 2 * PP);
    init(6'h19, 16'h0002);
    per(1'b1, n);
    chk(n, PP);
    init(6'h01, 16'h0002);
    per(1'b0, n);
    chk(n, PP);
    run <= 1'b0;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 4; c++) begin
        serialClockFromTx <= c[0];
        init({s[0], 2'h0, c[0], c[1], 1'b1}, 16'h0002);
        chk(txPinOe, c != 0);
        chk(serialExpansionMode, c == 3 && s == 0);
        if (c >= 2) chk(txPinOut, serialClockFromTx);
      end
    acc(1'b1, sbc_pkg::ADDR_DIV_HI, 8'h0, q);
    repeat (2) @(posedge core_clk);
    chk(serialIfReset, 1'b1);
    acc(1'b0, sbc_pkg::ADDR_STATUS, 8'h0, q);
    chk(q[sbc_pkg::ST_ENABLED], 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
